/* inc/strap_pkg.sv */
// Purpose: shared constants and carriers for strap capture and status indicators
// Assumes: register port with 16-bit data, byte addresses are index times four
// Notes: indices below are register numbers, not byte addresses
package strap_pkg;

	// ----------------------------------------
	// register map (index, byte address = index * 4)
	// ----------------------------------------
	localparam logic [4:0] REG_CTRL_IDX = 5'h00;
	localparam logic [4:0] REG_ADV_IDX = 5'h04;
	localparam logic [4:0] REG_VEND_IDX = 5'h17;
	localparam logic [4:0] REG_STRAP_IDX = 5'h18;
	localparam int REG_DATA_W = 16;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_ISOLATE_BIT = 10;
	localparam int VEND_ACT_BIT = 7;
	localparam int ADV_FD100_BIT = 8;
	localparam int ADV_HD100_BIT = 7;
	localparam int ADV_FD10_BIT = 6;
	localparam int ADV_HD10_BIT = 5;
	localparam int STS_ADDR_LSB = 0;
	localparam int STS_SCR_BIT = 5;
	localparam int STS_CODE_BIT = 6;
	localparam int STS_ALIGN_BIT = 7;
	localparam int STS_AN_BIT = 8;
	localparam int STS_FD100_BIT = 9;
	localparam int STS_HD100_BIT = 10;
	localparam int STS_FD10_BIT = 11;
	localparam int STS_HD10_BIT = 12;
	localparam int STS_ISO_BIT = 13;
	localparam int STS_FAST_BIT = 14;
	localparam int STS_FULL_BIT = 15;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic CTRL_ISOLATE_RST = 1'b0;
	localparam logic VEND_ACT_RST = 1'b0;
	localparam logic [4:0] STATION_RST = 5'h00;

	// ----------------------------------------
	// dual-function indicator pins
	// ----------------------------------------
	localparam int PIN_COUNT = 6;
	localparam int IND_RX = 0;
	localparam int IND_TXACT = 1;
	localparam int IND_COL = 2;
	localparam int IND_LINK = 3;
	localparam int IND_FD = 4;
	localparam int IND_SP = 5;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [4:0] station_address;
		logic scrambler_bypass_strap;
		logic block_code_bypass_strap;
		logic alignment_bypass_strap;
		logic autoneg_enable_strap;
		logic fast_full_duplex_strap;
		logic fast_half_duplex_strap;
		logic slow_full_duplex_strap;
		logic slow_half_duplex_strap;
	} strap_cfg_t;

	typedef struct packed {
		logic rx_active;
		logic tx_active;
		logic link_up;
		logic collision;
		logic an_fast;
		logic an_full;
	} link_status_t;

	typedef enum logic {PH_SAMPLE, PH_RUN} phase_t;

endpackage : strap_pkg

/* verif/board_straps.sv */
// Purpose: board side of the shared pins, strap resistors and indicator loads
// Assumes: each released pin is held at its strap level by its pull resistor
// Notes: a driven pin shows the device drive, a released pin the strap level
`timescale 1ns/10ps
module board_straps
(
	// strap resistor levels
	input wire logic [strap_pkg::PIN_COUNT-1:0] strap_levels,
	// drive from the device
	input wire logic [strap_pkg::PIN_COUNT-1:0] pin_out,
	input wire logic [strap_pkg::PIN_COUNT-1:0] pin_oe,
	// resolved pin levels
	output logic [strap_pkg::PIN_COUNT-1:0] pin_level
);
	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	always_comb
	begin
		for (int i = 0; i < strap_pkg::PIN_COUNT; i++)
		begin
			pin_level[i] = pin_oe[i] ? pin_out[i] : strap_levels[i];
		end
	end
endmodule : board_straps

/* verif/tb_strap_config_and_status_leds.sv */
// Purpose: self-checking bench for strap capture and status indicators
// Assumes: register port strobes driven right after rising edges
// Notes: indicator pins resolved through the board model
`timescale 1ns/10ps
module tb_strap_config_and_status_leds;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [6:0] reg_addr = 7'h00;
	logic [strap_pkg::REG_DATA_W-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [strap_pkg::REG_DATA_W-1:0] reg_rdata;
	logic [4:0] addr_s = 5'h00;
	logic an_s = 1'b0;
	logic fd100_s = 1'b0;
	logic hd100_s = 1'b0;
	logic [5:0] pin_s = 6'h00;
	logic [5:0] pin_in;
	logic [5:0] pin_out;
	logic [5:0] pin_oe;
	strap_pkg::link_status_t ls = '0;
	strap_pkg::strap_cfg_t cfg;
	logic [3:0] adv;
	logic op_fast;
	logic op_full;
	logic iso;
	logic mii_oe;
	logic tx_acc;
	logic rel;
	logic [15:0] rd;
	logic [5:0] on;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	// ----------------------------------------
	// clock, timeout, instances
	// ----------------------------------------
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			results();
		end
	end
	strap_config_and_status_leds u_strap_config_and_status_leds (.ref_clk(ref_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.station_address_straps(addr_s), .autoneg_enable_strap(an_s), .fast_full_duplex_strap(fd100_s),
		.fast_half_duplex_strap(hd100_s), .ind_pin_in(pin_in), .ind_pin_out(pin_out), .ind_pin_oe(pin_oe),
		.link_status(ls), .cfg(cfg), .adv_abilities(adv), .op_fast(op_fast), .op_full(op_full),
		.isolate_mode(iso), .mii_output_enable(mii_oe), .tx_input_accept(tx_acc), .addr_pins_released(rel));
	board_straps u_board_straps (.strap_levels(pin_s), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (e !== g)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [6:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : reg_read
	task automatic do_reset(input logic [4:0] a, input logic an, input logic f, input logic h, input logic [5:0] p);
		@(posedge ref_clk);
		rst <= 1'b1;
		addr_s <= a;
		an_s <= an;
		fd100_s <= f;
		hd100_s <= h;
		pin_s <= p;
		@(negedge ref_clk);
		chk("oe in reset", 16'h0000, {10'h000, pin_oe});
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("oe at capture", 16'h0000, {10'h000, pin_oe});
		chk("pins released", 16'h0001, {15'h0000, rel});
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("oe after capture", 16'h003F, {10'h000, pin_oe});
	endtask : do_reset
	task automatic ind_sweep(input logic v);
		for (int i = 0; i < 16; i++)
		begin
			@(posedge ref_clk);
			ls <= {i[3:0], 2'b10};
			@(posedge ref_clk);
			@(negedge ref_clk);
			on = {1'b1, 1'b0, i[1], i[0], i[2] | (v & i[3]), i[3]};
			chk("indicators", {10'h000, pin_s ^ on}, {10'h000, pin_out});
		end
		$display("indicator sweep done");
	endtask : ind_sweep
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		static logic [4:0] fa [4] = '{5'h01, 5'h02, 5'h03, 5'h1F};
		static logic [1:0] fs [4] = '{2'b10, 2'b01, 2'b00, 2'b00};
		static logic [5:0] fp [4] = '{6'h00, 6'h00, 6'h20, 6'h10};
		static logic [1:0] fe [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
		do_reset(5'h15, 1'b1, 1'b1, 1'b0, 6'b011010);
		@(posedge ref_clk);
		ls <= 6'b000010;
		@(negedge ref_clk);
		chk("cfg", 16'h15B9, {3'h0, cfg});
		chk("adv", 16'h0009, {12'h000, adv});
		chk("enables", 16'h0003, {14'h0000, mii_oe, tx_acc});
		reg_read(7'h60, rd);
		chk("status reg", 16'h53B5, rd);
		reg_write(7'h10, 16'hFFFF);
		reg_read(7'h10, rd);
		chk("adv reg", 16'h0120, rd);
		reg_read(7'h00, rd);
		chk("ctrl reg", 16'h0000, rd);
		reg_read(7'h7C, rd);
		chk("unmapped reg", 16'h0000, rd);
		@(negedge ref_clk);
		chk("rdata idle", 16'h0000, reg_rdata);
		ind_sweep(1'b0);
		reg_write(7'h5C, 16'h0080);
		reg_read(7'h5C, rd);
		chk("vendor reg", 16'h0080, rd);
		ind_sweep(1'b1);
		@(posedge ref_clk);
		addr_s <= 5'h0A;
		an_s <= 1'b0;
		reg_write(7'h00, 16'h0400);
		@(negedge ref_clk);
		chk("cfg held", 16'h15B9, {3'h0, cfg});
		chk("isolate on", 16'h0004, {13'h0000, iso, mii_oe, tx_acc});
		reg_write(7'h00, 16'h0000);
		@(negedge ref_clk);
		chk("isolate off", 16'h0003, {13'h0000, iso, mii_oe, tx_acc});
		$display("first strap set done");
		do_reset(5'h00, 1'b0, 1'b0, 1'b1, 6'h00);
		@(posedge ref_clk);
		ls <= 6'b000000;
		@(negedge ref_clk);
		chk("zero addr", 16'h0004, {13'h0000, iso, mii_oe, tx_acc});
		reg_read(7'h00, rd);
		chk("ctrl isolate", 16'h0400, rd);
		reg_write(7'h00, 16'h0000);
		@(negedge ref_clk);
		chk("isolate kept", 16'h0001, {15'h0000, iso});
		$display("zero address done");
		for (int k = 0; k < 4; k++)
		begin
			do_reset(fa[k], 1'b0, fs[k][1], fs[k][0], fp[k]);
			chk("adv forced", 16'h0000, {12'h000, adv});
			chk("forced mode", {14'h0000, fe[k]}, {14'h0000, op_fast, op_full});
			chk("speed duplex pins", {10'h000, fp[k] ^ {fe[k], 4'h0}}, {10'h000, pin_out});
		end
		$display("forced modes done");
		results();
	end
endmodule : tb_strap_config_and_status_leds

/* verilog/dual_pin_cell.sv */
// Purpose: one shared strap / indicator pin
// Assumes: capture is a one-cycle pulse, drive rises after it
// Notes: indicator is driven at the level opposite to the captured strap
`timescale 1ns/10ps
module dual_pin_cell
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control
	input wire logic capture,
	input wire logic drive,
	input wire logic indicator_on,
	// pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	// captured level
	output logic strap_value
);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic strap_q, strap_d;
	logic out_q, out_d;
	logic oe_q, oe_d;

	always_comb
	begin
		strap_d = capture ? pin_in : strap_q;
		oe_d = drive;
		out_d = drive ? (indicator_on ? ~strap_q : strap_q) : 1'b0;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			strap_q <= 1'b0;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			strap_q <= strap_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign strap_value = strap_q;
	assign pin_out = out_q;
	assign pin_oe = oe_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	polarity_drive_a: assert property (
		(drive && indicator_on && !capture) |=> (pin_out == ~strap_value))
		else $error("indicator not driven opposite to strap");

	strap_hold_a: assert property (
		(!capture && pin_oe) |=> $stable(strap_value))
		else $error("strap changed while pin drives");

endmodule : dual_pin_cell

/* verilog/strap_config_and_status_leds.sv */
// Purpose: latch configuration straps after reset, then drive status indicators
// Assumes: ref_clk 50 MHz, rst asynchronous active high, pins synchronous to ref_clk
// Notes: shared pins are undriven until one cycle after the strap capture
//
// Summary of operation
// - latch five address straps as station address
// - station address zero forces isolate mode
// - scrambler bypass strap skips scramble and descramble
// - block code bypass strap skips 4B/5B encoder
// - alignment bypass strap disables symbol alignment
// - autonegotiation strap enables or disables autonegotiation
// - ability straps set advertisement bits when negotiating
// - without autonegotiation, ability straps select speed/duplex
// - receive indicator on while receiving
// - activity bit clear: indicator shows transmit only
// - activity bit set: indicator shows receive or transmit
// - link indicator on while link valid
// - collision indicator on while collision seen
// - duplex indicator on in full duplex
// - speed indicator on at 100 Mbit/s
// - isolate bit initialised from zero station address
// - isolate ignores transmit inputs, floats outputs
`timescale 1ns/10ps
module strap_config_and_status_leds #(
	parameter int ADDR_W = 7
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [strap_pkg::REG_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [strap_pkg::REG_DATA_W-1:0] reg_rdata,
	// plain strap inputs
	input wire logic [4:0] station_address_straps,
	input wire logic autoneg_enable_strap,
	input wire logic fast_full_duplex_strap,
	input wire logic fast_half_duplex_strap,
	// shared strap / indicator pins
	input wire logic [strap_pkg::PIN_COUNT-1:0] ind_pin_in,
	output logic [strap_pkg::PIN_COUNT-1:0] ind_pin_out,
	output logic [strap_pkg::PIN_COUNT-1:0] ind_pin_oe,
	// link state from the datapath
	input wire strap_pkg::link_status_t link_status,
	// configuration out
	output strap_pkg::strap_cfg_t cfg,
	output logic [3:0] adv_abilities,
	output logic op_fast,
	output logic op_full,
	output logic isolate_mode,
	output logic mii_output_enable,
	output logic tx_input_accept,
	output logic addr_pins_released
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (ADDR_W < 7)
	begin : g_addr_chk
		$error("ADDR_W must be at least 7");
	end

	// ----------------------------------------
	// capture phase
	// ----------------------------------------
	strap_pkg::phase_t phase_q, phase_d;
	logic capture;
	logic run;

	always_comb
	begin
		unique case (phase_q)
			strap_pkg::PH_SAMPLE: phase_d = strap_pkg::PH_RUN;
			strap_pkg::PH_RUN: phase_d = strap_pkg::PH_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			phase_q <= strap_pkg::PH_SAMPLE;
		else
			phase_q <= phase_d;
	end

	assign capture = (phase_q == strap_pkg::PH_SAMPLE);
	assign run = (phase_q == strap_pkg::PH_RUN);
	assign addr_pins_released = run;

	// ----------------------------------------
	// plain straps
	// ----------------------------------------
	logic [4:0] station_q, station_d;
	logic an_q, an_d;
	logic fd100_q, fd100_d;
	logic hd100_q, hd100_d;

	always_comb
	begin
		station_d = capture ? station_address_straps : station_q;
		an_d = capture ? autoneg_enable_strap : an_q;
		fd100_d = capture ? fast_full_duplex_strap : fd100_q;
		hd100_d = capture ? fast_half_duplex_strap : hd100_q;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			station_q <= strap_pkg::STATION_RST;
			an_q <= 1'b0;
			fd100_q <= 1'b0;
			hd100_q <= 1'b0;
		end
		else
		begin
			station_q <= station_d;
			an_q <= an_d;
			fd100_q <= fd100_d;
			hd100_q <= hd100_d;
		end
	end

	// ----------------------------------------
	// shared pins
	// ----------------------------------------
	logic [strap_pkg::PIN_COUNT-1:0] pin_strap;
	logic [strap_pkg::PIN_COUNT-1:0] ind_on;
	logic vend_act_q, vend_act_d;

	always_comb
	begin
		ind_on = '0;
		ind_on[strap_pkg::IND_RX] = link_status.rx_active;
		ind_on[strap_pkg::IND_TXACT] = vend_act_q ? (link_status.rx_active | link_status.tx_active)
			: link_status.tx_active;
		ind_on[strap_pkg::IND_COL] = link_status.collision;
		ind_on[strap_pkg::IND_LINK] = link_status.link_up;
		ind_on[strap_pkg::IND_FD] = op_full;
		ind_on[strap_pkg::IND_SP] = op_fast;
	end

	for (genvar i = 0; i < strap_pkg::PIN_COUNT; i++)
	begin : g_pin
		dual_pin_cell u_cell (
			.ref_clk(ref_clk),
			.rst(rst),
			.capture(capture),
			.drive(run),
			.indicator_on(ind_on[i]),
			.pin_in(ind_pin_in[i]),
			.pin_out(ind_pin_out[i]),
			.pin_oe(ind_pin_oe[i]),
			.strap_value(pin_strap[i])
		);
	end

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	function automatic logic [1:0] forced_mode(input strap_pkg::strap_cfg_t c);
		if (c.fast_full_duplex_strap)
			return 2'b11;
		else if (c.fast_half_duplex_strap)
			return 2'b10;
		else if (c.slow_full_duplex_strap)
			return 2'b01;
		else
			return 2'b00;
	endfunction : forced_mode

	logic [1:0] forced;
	logic ctrl_iso_q, ctrl_iso_d;

	always_comb
	begin
		cfg.station_address = station_q;
		cfg.scrambler_bypass_strap = pin_strap[strap_pkg::IND_TXACT];
		cfg.block_code_bypass_strap = pin_strap[strap_pkg::IND_COL];
		cfg.alignment_bypass_strap = pin_strap[strap_pkg::IND_LINK];
		cfg.autoneg_enable_strap = an_q;
		cfg.fast_full_duplex_strap = fd100_q;
		cfg.fast_half_duplex_strap = hd100_q;
		cfg.slow_full_duplex_strap = pin_strap[strap_pkg::IND_SP];
		cfg.slow_half_duplex_strap = pin_strap[strap_pkg::IND_FD];
	end

	assign forced = forced_mode(cfg);
	assign adv_abilities = an_q ? {fd100_q, hd100_q, cfg.slow_full_duplex_strap, cfg.slow_half_duplex_strap}
		: 4'h0;
	assign op_fast = an_q ? link_status.an_fast : forced[1];
	assign op_full = an_q ? link_status.an_full : forced[0];
	assign isolate_mode = ctrl_iso_q | (station_q == 5'h00);
	assign mii_output_enable = run & ~isolate_mode;
	assign tx_input_accept = run & ~isolate_mode;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'({strap_pkg::REG_CTRL_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] ADV_ADDR = ADDR_W'({strap_pkg::REG_ADV_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] VEND_ADDR = ADDR_W'({strap_pkg::REG_VEND_IDX, 2'b00});
	localparam logic [ADDR_W-1:0] STRAP_ADDR = ADDR_W'({strap_pkg::REG_STRAP_IDX, 2'b00});

	logic [strap_pkg::REG_DATA_W-1:0] rdata_q, rdata_d;
	logic [strap_pkg::REG_DATA_W-1:0] rd_mux;

	always_comb
	begin
		ctrl_iso_d = ctrl_iso_q;
		vend_act_d = vend_act_q;
		if (capture)
			ctrl_iso_d = (station_address_straps == 5'h00);
		else if (reg_wr && reg_addr == CTRL_ADDR)
			ctrl_iso_d = reg_wdata[strap_pkg::CTRL_ISOLATE_BIT];
		if (reg_wr && reg_addr == VEND_ADDR)
			vend_act_d = reg_wdata[strap_pkg::VEND_ACT_BIT];
	end

	always_comb
	begin
		rd_mux = '0;
		case (reg_addr)
			CTRL_ADDR: rd_mux[strap_pkg::CTRL_ISOLATE_BIT] = ctrl_iso_q;
			ADV_ADDR:
			begin
				rd_mux[strap_pkg::ADV_FD100_BIT] = adv_abilities[3];
				rd_mux[strap_pkg::ADV_HD100_BIT] = adv_abilities[2];
				rd_mux[strap_pkg::ADV_FD10_BIT] = adv_abilities[1];
				rd_mux[strap_pkg::ADV_HD10_BIT] = adv_abilities[0];
			end
			VEND_ADDR: rd_mux[strap_pkg::VEND_ACT_BIT] = vend_act_q;
			STRAP_ADDR:
			begin
				rd_mux[strap_pkg::STS_ADDR_LSB +: 5] = station_q;
				rd_mux[strap_pkg::STS_SCR_BIT] = cfg.scrambler_bypass_strap;
				rd_mux[strap_pkg::STS_CODE_BIT] = cfg.block_code_bypass_strap;
				rd_mux[strap_pkg::STS_ALIGN_BIT] = cfg.alignment_bypass_strap;
				rd_mux[strap_pkg::STS_AN_BIT] = an_q;
				rd_mux[strap_pkg::STS_FD100_BIT] = fd100_q;
				rd_mux[strap_pkg::STS_HD100_BIT] = hd100_q;
				rd_mux[strap_pkg::STS_FD10_BIT] = cfg.slow_full_duplex_strap;
				rd_mux[strap_pkg::STS_HD10_BIT] = cfg.slow_half_duplex_strap;
				rd_mux[strap_pkg::STS_ISO_BIT] = isolate_mode;
				rd_mux[strap_pkg::STS_FAST_BIT] = op_fast;
				rd_mux[strap_pkg::STS_FULL_BIT] = op_full;
			end
			default: rd_mux = '0;
		endcase
		rdata_d = reg_rd ? rd_mux : '0;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_iso_q <= strap_pkg::CTRL_ISOLATE_RST;
			vend_act_q <= strap_pkg::VEND_ACT_RST;
			rdata_q <= '0;
		end
		else
		begin
			ctrl_iso_q <= ctrl_iso_d;
			vend_act_q <= vend_act_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence act_mode_s;
		run && vend_act_q && ind_pin_oe[strap_pkg::IND_TXACT]
			&& (link_status.rx_active || link_status.tx_active);
	endsequence

	sequence tx_only_idle_s;
		run && !vend_act_q && ind_pin_oe[strap_pkg::IND_TXACT] && !link_status.tx_active;
	endsequence

	address_latch_a: assert property (
		capture |=> (station_q == $past(station_address_straps)) ##1 $stable(station_q))
		else $error("station address not latched at capture");

	zero_isolate_a: assert property (
		(run && station_q == 5'h00) |-> (isolate_mode && !mii_output_enable))
		else $error("zero address did not isolate");

	scrambler_latch_a: assert property (
		capture |=> (cfg.scrambler_bypass_strap == $past(ind_pin_in[strap_pkg::IND_TXACT])))
		else $error("scrambler bypass not latched");

	code_latch_a: assert property (
		capture |=> (cfg.block_code_bypass_strap == $past(ind_pin_in[strap_pkg::IND_COL])))
		else $error("block code bypass not latched");

	align_latch_a: assert property (
		capture |=> (cfg.alignment_bypass_strap == $past(ind_pin_in[strap_pkg::IND_LINK])))
		else $error("alignment bypass not latched");

	autoneg_latch_a: assert property (
		capture |=> (cfg.autoneg_enable_strap == $past(autoneg_enable_strap)))
		else $error("autonegotiation strap not latched");

	advert_bits_a: assert property (
		(run && an_q) |-> (adv_abilities[3] == fd100_q && adv_abilities[0] == cfg.slow_half_duplex_strap))
		else $error("advertisement does not follow straps");

	forced_mode_a: assert property (
		(run && !an_q && fd100_q) |-> (op_fast && op_full))
		else $error("forced mode ignores 100 full strap");

	activity_led_a: assert property (
		act_mode_s |=> (ind_pin_out[strap_pkg::IND_TXACT] == ~pin_strap[strap_pkg::IND_TXACT]))
		else $error("activity indicator not asserted");

	tx_only_led_a: assert property (
		tx_only_idle_s |=> (ind_pin_out[strap_pkg::IND_TXACT] == pin_strap[strap_pkg::IND_TXACT]))
		else $error("transmit indicator asserted without transmit");

	link_led_a: assert property (
		(ind_pin_oe[strap_pkg::IND_LINK] && link_status.link_up)
			|=> (ind_pin_out[strap_pkg::IND_LINK] == ~pin_strap[strap_pkg::IND_LINK]))
		else $error("link indicator not asserted");

	isolate_init_a: assert property (
		capture |=> (ctrl_iso_q == ($past(station_address_straps) == 5'h00)))
		else $error("isolate bit not initialised from address");

	pins_quiet_a: assert property (
		capture |-> (ind_pin_oe == '0) ##1 (ind_pin_oe == '0) ##1 (ind_pin_oe == '1))
		else $error("shared pins driven too early or too late");

	read_data_a: assert property (
		!reg_rd |=> (reg_rdata == '0))
		else $error("read data present without read");

endmodule : strap_config_and_status_leds
